//--- hw/led_cfg_consts.svh
// Operation
// - two-bit short threshold held per channel
// - mask/open/short lock blocks threshold writes
// - threshold code selects 0.8/1.8/2.8/3.8 V
// - thresholds clear on every reset source
// - duty-adjust 0 halves PWM at 125C
// - duty halving only on PWM channels
// - control-data lock blocks five settings
// - duty-adjust clears on every reset source
// - shutdown enable 0 forces outputs off at 150C
// - shutdown enable survives thermal shutdown
// - clock source picks internal or external
// - clock source clears on hard reset only
// - external frequency 200/150 kHz, external mode
// - external frequency clears on hard reset
// - rise time 0.5 or 1.0 microseconds
// - rise time clears on every reset source
`ifndef LED_CFG_CONSTS_SVH
`define LED_CFG_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CMD          8'h00
`define OFF_THRESH       8'h04
`define OFF_CTRL         8'h08
`define OFF_STATUS       8'h0c

// ****************************************
// command register bits (write one to act)
// ****************************************
`define CMD_LOCK_OUT     0
`define CMD_UNLOCK_OUT   1
`define CMD_LOCK_CTRL    2
`define CMD_UNLOCK_CTRL  3
`define CMD_SOFT_RESET   4

// ****************************************
// control register bits
// ****************************************
`define CTRL_DUTY_DIS    0
`define CTRL_TSD_DIS     1
`define CTRL_CLK_SRC     2
`define CTRL_EXT_FREQ    3
`define CTRL_RISE        4

// ****************************************
// status register bits
// ****************************************
`define STAT_OUT_LOCK    0
`define STAT_CTRL_LOCK   1
`define STAT_SHUTDOWN    2
`define STAT_DERATE      3

// ****************************************
// reset values and responses
// ****************************************
`define THRESH_RST       24'h000000
`define BIT_RST          1'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ****************************************
// analog selections as numbers
// ****************************************
`define LEVEL_MV_0       12'h320
`define LEVEL_MV_1       12'h708
`define LEVEL_MV_2       12'haf0
`define LEVEL_MV_3       12'hed8
`define RISE_NS_0        11'h1f4
`define RISE_NS_1        11'h3e8
`define EXT_KHZ_0        8'hc8
`define EXT_KHZ_1        8'h96
`define EXT_KHZ_NONE     8'h00

`endif

//--- hw/led_cfg_pkg.sv
package led_cfg_pkg;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

  typedef enum logic [2:0] {
    REG_CMD    = 3'b000,
    REG_THRESH = 3'b001,
    REG_CTRL   = 3'b010,
    REG_STATUS = 3'b011,
    REG_NONE   = 3'b100
  } reg_sel_e;

  typedef struct packed {
    logic        out_lock;
    logic        ctrl_lock;
    logic [23:0] short_thresh;
    logic        hot_duty_adjust_disable;
    logic        thermal_shutdown_disable;
    logic        clock_source_select;
    logic        ext_clock_freq_select;
    logic        rise_time_select;
  } store_s;

  typedef struct packed {
    wr_state_e   wr_state;
    logic [1:0]  bresp;
    rd_state_e   rd_state;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        tsd_prev;
    logic        force_off;
    logic [11:0] duty_halve;
  } bus_s;

endpackage

//--- hw/cfg_if.sv
interface cfg_if;
  import led_cfg_pkg::*;
  logic        hard_reset;
  logic        soft_reset;
  logic        tsd_entry;
  logic        lock_out;
  logic        unlock_out;
  logic        lock_ctrl;
  logic        unlock_ctrl;
  logic        wr_thresh;
  logic        wr_ctrl;
  logic [31:0] wdata;
  store_s      cfg;

  modport store (
    input  hard_reset, soft_reset, tsd_entry, lock_out, unlock_out,
    input  lock_ctrl, unlock_ctrl, wr_thresh, wr_ctrl, wdata,
    output cfg
  );

  modport ctl (
    output hard_reset, soft_reset, tsd_entry, lock_out, unlock_out,
    output lock_ctrl, unlock_ctrl, wr_thresh, wr_ctrl, wdata,
    input  cfg
  );
endinterface

//--- hw/led_cfg_store.sv
`include "led_cfg_consts.svh"

module led_cfg_store
  import led_cfg_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // command side
  cfg_if.store      c
);

  store_s q;
  store_s next_q;

  always_comb
  begin
    next_q = q;
    // lock state machines; unlock placed last so it wins a tie
    if (c.lock_out)
      next_q.out_lock = 1'b1;
    if (c.unlock_out)
      next_q.out_lock = 1'b0;
    if (c.lock_ctrl)
      next_q.ctrl_lock = 1'b1;
    if (c.unlock_ctrl)
      next_q.ctrl_lock = 1'b0;
    // a locked write is dropped quietly and the old value stays
    if (c.wr_thresh && !q.out_lock)
      next_q.short_thresh = c.wdata[23:0];
    if (c.wr_ctrl && !q.ctrl_lock)
    begin
      next_q.hot_duty_adjust_disable  = c.wdata[`CTRL_DUTY_DIS];
      next_q.thermal_shutdown_disable = c.wdata[`CTRL_TSD_DIS];
      next_q.clock_source_select      = c.wdata[`CTRL_CLK_SRC];
      next_q.ext_clock_freq_select    = c.wdata[`CTRL_EXT_FREQ];
      next_q.rise_time_select         = c.wdata[`CTRL_RISE];
    end
    if (c.soft_reset || c.tsd_entry)
    begin
      next_q.short_thresh            = `THRESH_RST;
      next_q.hot_duty_adjust_disable = `BIT_RST;
      next_q.rise_time_select        = `BIT_RST;
    end
    // thermal shutdown entry leaves the disable bit alone
    if (c.soft_reset)
      next_q.thermal_shutdown_disable = `BIT_RST;
    if (c.hard_reset)
    begin
      next_q.out_lock                 = `BIT_RST;
      next_q.ctrl_lock                = `BIT_RST;
      next_q.short_thresh             = `THRESH_RST;
      next_q.hot_duty_adjust_disable  = `BIT_RST;
      next_q.thermal_shutdown_disable = `BIT_RST;
      next_q.clock_source_select      = `BIT_RST;
      next_q.ext_clock_freq_select    = `BIT_RST;
      next_q.rise_time_select         = `BIT_RST;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.out_lock                 <= `BIT_RST;
      q.ctrl_lock                <= `BIT_RST;
      q.short_thresh             <= `THRESH_RST;
      q.hot_duty_adjust_disable  <= `BIT_RST;
      q.thermal_shutdown_disable <= `BIT_RST;
      q.clock_source_select      <= `BIT_RST;
      q.ext_clock_freq_select    <= `BIT_RST;
      q.rise_time_select         <= `BIT_RST;
    end
    else
      q <= next_q;
  end

  assign c.cfg = q;

endmodule

//--- hw/led_driver_protected_config.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`include "led_cfg_consts.svh"

module led_driver_protected_config
  import led_cfg_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int CHANNELS = 12
)
(
  // clock and reset
  input  wire  logic                    clock,
  input  wire  logic                    rst_n,
  // axi4-lite write address
  input  wire  logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire  logic                    s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire  logic [31:0]             s_axi_wdata,
  input  wire  logic [3:0]              s_axi_wstrb,
  input  wire  logic                    s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire  logic                    s_axi_bready,
  // axi4-lite read address
  input  wire  logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire  logic                    s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire  logic                    s_axi_rready,
  // reset sources
  input  wire  logic                    reset_pin_n,
  input  wire  logic                    supply_detect_reset,
  // temperature sensors and channel modes
  input  wire  logic                    temp_125_detect,
  input  wire  logic                    temp_150_detect,
  input  wire  logic [CHANNELS-1:0]     pwm_channel_mode,
  // fundamental clock sources
  input  wire  logic                    internal_osc_clock,
  input  wire  logic                    osc_clock_input,
  // configuration towards the analog side
  output logic [CHANNELS-1:0][1:0]      short_thresh,
  output logic [CHANNELS-1:0][11:0]     short_detect_level,
  output logic [CHANNELS-1:0]           duty_halve,
  output logic                          outputs_force_off,
  output logic                          internal_osc_enable,
  output logic                          fundamental_clock,
  output logic [7:0]                    ext_clock_khz,
  output logic [10:0]                   rise_time_ns
);

  // ****************************************
  // helpers
  // ****************************************

  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = REG_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[7:0])
        `OFF_CMD:    sel = REG_CMD;
        `OFF_THRESH: sel = REG_THRESH;
        `OFF_CTRL:   sel = REG_CTRL;
        `OFF_STATUS: sel = REG_STATUS;
        default:     sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_word[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [11:0] level_mv(input logic [1:0] code);
    logic [11:0] mv;
    case (code)
      2'h0:    mv = `LEVEL_MV_0;
      2'h1:    mv = `LEVEL_MV_1;
      2'h2:    mv = `LEVEL_MV_2;
      2'h3:    mv = `LEVEL_MV_3;
      default: mv = `LEVEL_MV_0;
    endcase
    return mv;
  endfunction

  // ****************************************
  // settings store
  // ****************************************

  cfg_if c ();

  led_cfg_store u_store (
    .clock (clock),
    .rst_n (rst_n),
    .c     (c)
  );

  bus_s        st;
  bus_s        next_st;
  reg_sel_e    wr_sel;
  reg_sel_e    rd_sel;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] thresh_word;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] cmd_bits;
  logic        tsd_active;

  assign wr_sel  = decode(s_axi_awaddr);
  assign rd_sel  = decode(s_axi_araddr);
  // address and data are taken together, so neither can be stranded
  assign wr_take = (st.wr_state == WR_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign rd_take = (st.rd_state == RD_IDLE) && s_axi_arvalid;

  assign thresh_word = {8'h00, c.cfg.short_thresh};
  assign ctrl_word   = {27'h0000000,
                        c.cfg.rise_time_select,
                        c.cfg.ext_clock_freq_select,
                        c.cfg.clock_source_select,
                        c.cfg.thermal_shutdown_disable,
                        c.cfg.hot_duty_adjust_disable};
  assign status_word = {28'h0000000,
                        |st.duty_halve,
                        st.force_off,
                        c.cfg.ctrl_lock,
                        c.cfg.out_lock};

  // commands act only through the low byte lane
  assign cmd_bits = (wr_take && wr_sel == REG_CMD && s_axi_wstrb[0]) ? s_axi_wdata : 32'h00000000;

  // ****************************************
  // commands to the store
  // ****************************************

  assign c.hard_reset  = !reset_pin_n || supply_detect_reset;
  assign c.soft_reset  = cmd_bits[`CMD_SOFT_RESET];
  assign c.lock_out    = cmd_bits[`CMD_LOCK_OUT];
  assign c.unlock_out  = cmd_bits[`CMD_UNLOCK_OUT];
  assign c.lock_ctrl   = cmd_bits[`CMD_LOCK_CTRL];
  assign c.unlock_ctrl = cmd_bits[`CMD_UNLOCK_CTRL];
  // the host must unlock first; a locked write is silently dropped
  assign c.wr_thresh   = wr_take && (wr_sel == REG_THRESH);
  assign c.wr_ctrl     = wr_take && (wr_sel == REG_CTRL);
  assign c.wdata       = (wr_sel == REG_THRESH) ? merge(thresh_word, s_axi_wdata, s_axi_wstrb)
                                                : merge(ctrl_word, s_axi_wdata, s_axi_wstrb);

  // shutdown is only armed while the disable bit is clear
  assign tsd_active  = temp_150_detect && !c.cfg.thermal_shutdown_disable;
  assign c.tsd_entry = tsd_active && !st.tsd_prev;

  // ****************************************
  // bus and thermal state
  // ****************************************

  always_comb
  begin
    next_st            = st;
    next_st.tsd_prev   = tsd_active;
    next_st.force_off  = tsd_active;
    // halving applies to pwm channels only, and only when enabled
    next_st.duty_halve = (temp_125_detect && !c.cfg.hot_duty_adjust_disable)
                         ? pwm_channel_mode : '0;
    case (st.wr_state)
      WR_IDLE:
      begin
        if (wr_take)
        begin
          next_st.wr_state = WR_RESP;
          // a refused locked write still answers okay
          next_st.bresp    = (wr_sel == REG_NONE || wr_sel == REG_STATUS)
                             ? `RESP_SLVERR : `RESP_OKAY;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
          next_st.wr_state = WR_IDLE;
      end
      default:
        next_st.wr_state = WR_IDLE;
    endcase
    case (st.rd_state)
      RD_IDLE:
      begin
        if (rd_take)
        begin
          next_st.rd_state = RD_RESP;
          next_st.rresp    = `RESP_OKAY;
          case (rd_sel)
            REG_CMD:    next_st.rdata = 32'h00000000;
            REG_THRESH: next_st.rdata = thresh_word;
            REG_CTRL:   next_st.rdata = ctrl_word;
            REG_STATUS: next_st.rdata = status_word;
            default:
            begin
              next_st.rdata = 32'h00000000;
              next_st.rresp = `RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP:
      begin
        if (s_axi_rready)
          next_st.rd_state = RD_IDLE;
      end
      default:
        next_st.rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.wr_state   <= WR_IDLE;
      st.bresp      <= `RESP_OKAY;
      st.rd_state   <= RD_IDLE;
      st.rresp      <= `RESP_OKAY;
      st.rdata      <= 32'h00000000;
      st.tsd_prev   <= 1'b0;
      st.force_off  <= 1'b0;
      st.duty_halve <= 12'h000;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // bus outputs
  // ****************************************

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = (st.wr_state == WR_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = (st.rd_state == RD_RESP);
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // ****************************************
  // configuration outputs
  // ****************************************

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
      assign short_thresh[ch]       = c.cfg.short_thresh[ch*2 +: 2];
      assign short_detect_level[ch] = level_mv(c.cfg.short_thresh[ch*2 +: 2]);
    end
  endgenerate

  assign duty_halve        = st.duty_halve;
  assign outputs_force_off = st.force_off;

  // internal oscillator runs while the source bit is clear
  assign internal_osc_enable = !c.cfg.clock_source_select;
  assign fundamental_clock   = c.cfg.clock_source_select ? osc_clock_input : internal_osc_clock;

  // the frequency choice means nothing in internal mode
  assign ext_clock_khz = !c.cfg.clock_source_select ? `EXT_KHZ_NONE
                       : (c.cfg.ext_clock_freq_select ? `EXT_KHZ_1 : `EXT_KHZ_0);

  assign rise_time_ns = c.cfg.rise_time_select ? `RISE_NS_1 : `RISE_NS_0;

endmodule

//--- tb/led_cfg_monitor.sv
module led_cfg_monitor
  import led_cfg_pkg::*;
#(
  parameter int CHANNELS = 12
)
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // pins seen by the block
  input  wire logic                      reset_pin_n,
  input  wire logic                      supply_detect_reset,
  input  wire logic                      temp_125_detect,
  input  wire logic                      temp_150_detect,
  input  wire logic [CHANNELS-1:0]       pwm_channel_mode,
  input  wire logic                      internal_osc_clock,
  input  wire logic                      osc_clock_input,
  // configuration outputs
  input  wire logic [CHANNELS-1:0][1:0]  short_thresh,
  input  wire logic [CHANNELS-1:0][11:0] short_detect_level,
  input  wire logic [CHANNELS-1:0]       duty_halve,
  input  wire logic                      outputs_force_off,
  input  wire logic                      internal_osc_enable,
  input  wire logic                      fundamental_clock,
  input  wire logic [7:0]                ext_clock_khz,
  input  wire logic [10:0]               rise_time_ns
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking dflt @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_lvl
    AST_LEVEL: assert property (short_detect_level[i] == 12'(800 + 1000 * short_thresh[i]))
      else $error("short level does not follow threshold code");
  end
  AST_RISE: assert property (rise_time_ns == 11'd500 || rise_time_ns == 11'd1000)
    else $error("rise time is not a legal setting");
  AST_EXT_OFF: assert property (internal_osc_enable |-> ext_clock_khz == 8'd0)
    else $error("external frequency shown in internal mode");
  AST_EXT_ON: assert property (!internal_osc_enable |-> ext_clock_khz inside {8'd200, 8'd150})
    else $error("external frequency not declared in external mode");
  AST_FCLK: assert property (fundamental_clock == (internal_osc_enable ? internal_osc_clock : osc_clock_input))
    else $error("fundamental clock from wrong source");
  AST_DUTY_PWM: assert property ((duty_halve & ~$past(pwm_channel_mode)) == '0)
    else $error("duty halving on a non pwm channel");
  AST_DUTY_COOL: assert property (!$past(temp_125_detect) |-> duty_halve == '0)
    else $error("duty halved without hot sensor");
  AST_FORCE_COOL: assert property (!$past(temp_150_detect) |-> !outputs_force_off)
    else $error("outputs forced off without shutdown sensor");
  AST_ENTRY: assert property ($rose(outputs_force_off) |-> short_thresh == '0 && rise_time_ns == 11'd500)
    else $error("shutdown entry kept settings");
  AST_HARD: assert property (!$past(reset_pin_n) || $past(supply_detect_reset)
    |-> short_thresh == '0 && internal_osc_enable && ext_clock_khz == 8'd0)
    else $error("hard reset kept settings");
endmodule

bind led_driver_protected_config led_cfg_monitor #(.CHANNELS(CHANNELS)) u_led_cfg_monitor (
  .clock, .rst_n, .reset_pin_n, .supply_detect_reset, .temp_125_detect, .temp_150_detect,
  .pwm_channel_mode, .internal_osc_clock, .osc_clock_input, .short_thresh, .short_detect_level,
  .duty_halve, .outputs_force_off, .internal_osc_enable, .fundamental_clock, .ext_clock_khz, .rise_time_ns
);

//--- tb/ext_clock_src.sv
module ext_clock_src
(
  // mode taken from the device settings
  input  wire logic enable,
  input  wire logic slow,
  // clock towards the device
  output logic      osc_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // grounded while unused; half periods give 200 or 150 khz
  always
  begin
    osc_clock_input = 1'b0;
    wait (enable);
    while (enable)
    begin
      #(slow ? 3333 : 2500);
      osc_clock_input = ~osc_clock_input;
    end
  end
endmodule

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_cfg_pkg::*;

  logic              clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, ext_clock_khz;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [3:0]        s_axi_wstrb;
  logic              reset_pin_n, supply_detect_reset, temp_125_detect, temp_150_detect;
  logic              internal_osc_clock, osc_clock_input, outputs_force_off, internal_osc_enable;
  logic              fundamental_clock;
  logic [11:0]       pwm_channel_mode, duty_halve;
  logic [11:0][1:0]  short_thresh;
  logic [11:0][11:0] short_detect_level;
  logic [10:0]       rise_time_ns;
  int                failures, n_compared;

  led_driver_protected_config u_led_driver_protected_config (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .reset_pin_n, .supply_detect_reset, .temp_125_detect, .temp_150_detect, .pwm_channel_mode,
    .internal_osc_clock, .osc_clock_input, .short_thresh, .short_detect_level, .duty_halve,
    .outputs_force_off, .internal_osc_enable, .fundamental_clock, .ext_clock_khz, .rise_time_ns
  );
  ext_clock_src u_ext_clock_src (
    .enable          (!internal_osc_enable),
    .slow            (ext_clock_khz == 8'd150),
    .osc_clock_input (osc_clock_input)
  );

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    // raised only once the request is taken, so back-to-back calls never lower and raise it in one step
    s_axi_bready  <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic stop_test();
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // clocks and watchdog
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    internal_osc_clock = 1'b0;
    forever #100 internal_osc_clock = ~internal_osc_clock;
  end

  // sequence needs about a thousand cycles; a hang is stopped at the 50000-cycle run limit
  initial
  begin
    #400000;
    failures++;
    stop_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {supply_detect_reset, temp_125_detect, temp_150_detect, pwm_channel_mode} = '0;
    reset_pin_n = 1'b1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    chk(32'(rise_time_ns), 32'd500);
    wr(8'h04, 32'h00e4e4e4, 2'h0);
    rd(8'h04, 32'h00e4e4e4, 2'h0);
    for (int i = 0; i < 12; i++)
      chk(32'(short_detect_level[i]), 800 + 1000 * (i % 4));
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    rd(8'h04, 32'h00e4e4e4, 2'h0);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h00, 32'h2, 2'h0);
    wr(8'h04, 32'h00ffffff, 2'h0);
    rd(8'h04, 32'h00ffffff, 2'h0);
    wr(8'h08, 32'h1c, 2'h0);
    chk(32'(ext_clock_khz), 32'd150);
    chk(32'(rise_time_ns), 32'd1000);
    chk(32'(internal_osc_enable), 32'h0);
    repeat (900) @(posedge clock);
    wr(8'h08, 32'h14, 2'h0);
    chk(32'(ext_clock_khz), 32'd200);
    wr(8'h00, 32'h4, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 32'h14, 2'h0);
    wr(8'h00, 32'h8, 2'h0);
    pwm_channel_mode <= 12'h0a5;
    temp_125_detect  <= 1'b1;
    wr(8'h08, 32'h0, 2'h0);
    repeat (2) @(posedge clock);
    chk(32'(duty_halve), 32'h0a5);
    rd(8'h0c, 32'h8, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    repeat (2) @(posedge clock);
    chk(32'(duty_halve), 32'h0);
    temp_125_detect <= 1'b0;
    wr(8'h08, 32'h1f, 2'h0);
    wr(8'h00, 32'h10, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0c, 2'h0);
    wr(8'h04, 32'h00aaaaaa, 2'h0);
    wr(8'h08, 32'h1d, 2'h0);
    temp_150_detect <= 1'b1;
    repeat (2) @(posedge clock);
    chk(32'(outputs_force_off), 32'h1);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0c, 2'h0);
    temp_150_detect <= 1'b0;
    wr(8'h08, 32'h02, 2'h0);
    temp_150_detect <= 1'b1;
    repeat (2) @(posedge clock);
    chk(32'(outputs_force_off), 32'h0);
    temp_150_detect <= 1'b0;
    // pin reset first, then supply detect
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h08, 32'h1c, 2'h0);
      reset_pin_n         <= k[0];
      supply_detect_reset <= k[0];
      @(posedge clock);
      reset_pin_n         <= 1'b1;
      supply_detect_reset <= 1'b0;
      @(posedge clock);
      rd(8'h08, 32'h0, 2'h0);
    end
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h0c, 32'hf, 2'h2);
    stop_test();
  end
endmodule
